//--- dasc_channel.v
`include "dasc_defs.vh"

// one serial channel: transmitter with holding register, receiver with 4-deep fifo
module dasc_channel #(
  parameter BIT_CLKS = 434,
  parameter FIFO_AW  = 2
) (
  // clock and reset
  input  wire       clock_in,
  input  wire       rst_in,
  input  wire       halt_in,
  // register side
  input  wire [7:0] ctla_in,
  input  wire [7:0] ctlb_in,
  input  wire       txh_wr_in,
  input  wire [7:0] wdata_in,
  input  wire       rx_pop_in,
  input  wire       err_clr_in,
  output wire [7:0] txh_out,
  output wire [7:0] rxh_out,
  output wire [7:0] stat_out,
  output wire       mpb_out,
  // serial pins
  input  wire       serial_in_pin_in,
  output wire       serial_out_pin_out
);

  localparam DEPTH = 1 << FIFO_AW;
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;
  localparam RX_IDLE = 2'b00;
  localparam RX_SAMP = 2'b01;
  localparam RX_DONE = 2'b10;

  // frame length in bits including start: start + data + parity/mpb + stop
  function [3:0] frame_bits;
    input [7:0] a;
    input [7:0] b;
    begin
      frame_bits = `DASC_FRAME_BASE + {3'h0, a[`DASC_CA_WIDTH]} + {3'h0, a[`DASC_CA_STOP]}
                 + {3'h0, a[`DASC_CA_PARITY] | b[`DASC_CB_MP]};
    end
  endfunction

  wire       mp_sel     = ctlb_in[`DASC_CB_MP];
  wire       par_on     = ctla_in[`DASC_CA_PARITY] & ~mp_sel;
  wire [3:0] nbits      = frame_bits(ctla_in, ctlb_in);
  wire       tx_on      = ctla_in[`DASC_CA_TXON] & ~halt_in;
  wire       rx_on      = ctla_in[`DASC_CA_RXON] & ~halt_in;

  // ---------------- transmitter ----------------
  reg [7:0]  txh_q;
  reg        txe_q;
  reg        tx_st_q;
  reg [11:0] tx_sh_q;
  reg [3:0]  tx_cnt_q;
  reg [15:0] tx_div_q;
  reg        txd_q;
  wire [7:0] tx_dat     = ctla_in[`DASC_CA_WIDTH] ? txh_q : {1'b0, txh_q[6:0]};
  wire       tx_par     = ^tx_dat ^ ctlb_in[`DASC_CB_PEO];
  wire       tx_xbit    = mp_sel ? ctlb_in[`DASC_CB_MPBT] : tx_par;
  wire       tx_tick    = (tx_div_q == BIT_CLKS[15:0] - 16'h0001);

  // frame image, lsb first: start, data, optional extra bit, stops
  wire [11:0] tx_img = ctla_in[`DASC_CA_WIDTH] ?
    {2'b11, tx_xbit, tx_dat, 1'b0} :
    {3'b111, tx_xbit, tx_dat[6:0], 1'b0};
  wire [11:0] tx_img2 = (par_on | mp_sel) ? tx_img :
    (ctla_in[`DASC_CA_WIDTH] ? {3'b111, tx_dat, 1'b0} : {4'hF, tx_dat[6:0], 1'b0});

  // holding register and shifter; abort keeps the empty flag as it was
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      txh_q    <= 8'h00;
      txe_q    <= 1'b1;
      tx_st_q  <= TX_IDLE;
      tx_sh_q  <= 12'hFFF;
      tx_cnt_q <= 4'h0;
      tx_div_q <= 16'h0000;
      txd_q    <= 1'b1;
    end else begin
      if (txh_wr_in) begin
        txh_q <= wdata_in;
        txe_q <= 1'b0;
      end
      if (!tx_on) begin
        tx_st_q <= TX_IDLE;
        txd_q   <= 1'b1;
      end else begin
        case (tx_st_q)
          TX_IDLE: begin
            txd_q <= 1'b1;
            if (!txe_q) begin
              tx_sh_q  <= tx_img2;
              tx_cnt_q <= nbits;
              tx_div_q <= 16'h0000;
              tx_st_q  <= TX_SEND;
              if (!txh_wr_in) begin
                txe_q <= 1'b1;
              end
            end
          end
          TX_SEND: begin
            txd_q <= tx_sh_q[0];
            if (tx_tick) begin
              tx_div_q <= 16'h0000;
              tx_sh_q  <= {1'b1, tx_sh_q[11:1]};
              tx_cnt_q <= tx_cnt_q - 4'h1;
              if (tx_cnt_q == 4'h1) begin
                tx_st_q <= TX_IDLE;
              end
            end else begin
              tx_div_q <= tx_div_q + 16'h0001;
            end
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  assign serial_out_pin_out = txd_q;
  assign txh_out            = txh_q;

  // ---------------- receiver ----------------
  reg [1:0]  rx_st_q;
  reg [15:0] rx_div_q;
  reg [3:0]  rx_cnt_q;
  reg [11:0] rx_sh_q;
  reg        rx_full_q;
  reg [7:0]  rx_hold_q;
  reg [3:0]  rx_hstat_q;
  reg        ovr_pend_q;
  reg        mpb_q;
  reg [7:0]  fd_q [0:DEPTH-1];
  reg [3:0]  fs_q [0:DEPTH-1];
  reg [FIFO_AW-1:0] wp_q;
  reg [FIFO_AW-1:0] rp_q;
  reg [FIFO_AW:0]   cnt_q;
  reg [3:0]  err_q;

  // realign the assembled frame so the start bit lands at bit 0 and data starts at bit 1
  wire [11:0] rx_fr  = rx_sh_q >> (4'hC - nbits);
  wire [7:0]  rx_dat = ctla_in[`DASC_CA_WIDTH] ? rx_fr[8:1] : {1'b0, rx_fr[7:1]};
  wire        rx_x   = ctla_in[`DASC_CA_WIDTH] ? rx_fr[9] : rx_fr[8];
  wire        rx_stp = rx_fr[nbits - 4'h1];
  wire        rx_pe  = par_on & (^rx_dat ^ rx_x ^ ctlb_in[`DASC_CB_PEO]);
  wire        rx_brk = ~|rx_fr;
  wire        rx_keep = ~(mp_sel & ctla_in[`DASC_CA_WAKE]) | rx_x;
  wire        fifo_full = (cnt_q == DEPTH[FIFO_AW:0]);
  wire        do_pop  = rx_pop_in & (cnt_q != {(FIFO_AW+1){1'b0}});
  wire        do_push = rx_full_q & (~fifo_full | do_pop);
  wire        rx_mid  = (rx_div_q == {1'b0, BIT_CLKS[15:1]});
  wire        rx_tick = (rx_div_q == BIT_CLKS[15:0] - 16'h0001);

  // shifter samples mid-bit and keeps shifting even when the fifo is full
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_st_q    <= RX_IDLE;
      rx_div_q   <= 16'h0000;
      rx_cnt_q   <= 4'h0;
      rx_sh_q    <= 12'h000;
      rx_full_q  <= 1'b0;
      rx_hold_q  <= 8'h00;
      rx_hstat_q <= 4'h0;
      ovr_pend_q <= 1'b0;
      mpb_q      <= 1'b0;
      wp_q       <= {FIFO_AW{1'b0}};
      rp_q       <= {FIFO_AW{1'b0}};
      cnt_q      <= {(FIFO_AW+1){1'b0}};
    end else if (halt_in) begin
      rx_st_q   <= RX_IDLE;
      rx_full_q <= 1'b0;
      ovr_pend_q <= 1'b0;
      wp_q      <= {FIFO_AW{1'b0}};
      rp_q      <= {FIFO_AW{1'b0}};
      cnt_q     <= {(FIFO_AW+1){1'b0}};
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_div_q <= 16'h0000;
          rx_cnt_q <= 4'h0;
          if (rx_on && !serial_in_pin_in) begin
            rx_st_q <= RX_SAMP;
          end
        end
        RX_SAMP: begin
          rx_div_q <= rx_tick ? 16'h0000 : rx_div_q + 16'h0001;
          if (rx_mid) begin
            rx_sh_q  <= {serial_in_pin_in, rx_sh_q[11:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'h0 && serial_in_pin_in) begin
              rx_st_q <= RX_IDLE; // false start
            end else if (rx_cnt_q == nbits - 4'h1) begin
              rx_st_q <= RX_DONE;
            end
          end
        end
        RX_DONE: begin
          rx_st_q <= RX_IDLE;
          if (rx_keep) begin
            mpb_q <= rx_x;
            if (rx_full_q && !do_push) begin
              ovr_pend_q <= 1'b1;
            end else begin
              rx_full_q  <= 1'b1;
              rx_hold_q  <= rx_dat;
              rx_hstat_q <= {1'b0, rx_pe, ~rx_stp & ~rx_brk, rx_brk};
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
      // shifter into fifo; overrun rides on the last good entry
      if (do_push) begin
        fd_q[wp_q] <= rx_hold_q;
        fs_q[wp_q] <= rx_hstat_q;
        wp_q <= wp_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
        if (!(rx_st_q == RX_DONE && rx_keep)) begin
          rx_full_q <= 1'b0;
        end
      end
      if (ovr_pend_q && cnt_q != {(FIFO_AW+1){1'b0}} && !do_push) begin
        fs_q[wp_q - {{(FIFO_AW-1){1'b0}}, 1'b1}][3] <= 1'b1;
        ovr_pend_q <= 1'b0;
      end
      if (do_pop) begin
        rp_q <= rp_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
      end
      cnt_q <= cnt_q + {{FIFO_AW{1'b0}}, do_push} - {{FIFO_AW{1'b0}}, do_pop};
    end
  end

  // sticky error flags follow the head entry; set wins over clear
  wire [3:0] head_st = (cnt_q != {(FIFO_AW+1){1'b0}}) ? fs_q[rp_q] : 4'h0;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      err_q <= 4'h0;
    end else if (halt_in) begin
      err_q <= 4'h0;
    end else begin
      err_q <= (err_clr_in ? 4'h0 : err_q) | head_st;
    end
  end

  assign rxh_out  = (cnt_q != {(FIFO_AW+1){1'b0}}) ? fd_q[rp_q] : 8'h00;
  assign mpb_out  = mpb_q;
  // empty fifo reads clear; the data-available flag is set by the first push
  assign stat_out = {(cnt_q != {(FIFO_AW+1){1'b0}}), err_q[3], err_q[2], err_q[1],
                     err_q[0], 1'b0, txe_q, 1'b0};

endmodule

//--- dasc_defs.vh
`ifndef DASC_DEFS_VH
`define DASC_DEFS_VH

// register addresses for the I/O space (8-bit)
`define DASC_ADDR_CTLA0    8'h00
`define DASC_ADDR_CTLA1    8'h01
`define DASC_ADDR_CTLB0    8'h02
`define DASC_ADDR_CTLB1    8'h03
`define DASC_ADDR_STAT0    8'h04
`define DASC_ADDR_STAT1    8'h05
`define DASC_ADDR_TXH0     8'h06
`define DASC_ADDR_TXH1     8'h07
`define DASC_ADDR_RXH0     8'h08
`define DASC_ADDR_RXH1     8'h09

// control register A fields
`define DASC_CA_WAKE       7
`define DASC_CA_RXON       6
`define DASC_CA_TXON       5
`define DASC_CA_EFR        3
`define DASC_CA_WIDTH      2
`define DASC_CA_PARITY     1
`define DASC_CA_STOP       0

// control register B fields
`define DASC_CB_MPBT       7
`define DASC_CB_MP         6
`define DASC_CB_PEO        4

// status register fields
`define DASC_ST_RDA        7
`define DASC_ST_OVERRUN_FLAG       6
`define DASC_ST_PAR        5
`define DASC_ST_FRM        4
`define DASC_ST_BRK        3
`define DASC_ST_TXE        1

// reset values
`define DASC_CTLA_RST      8'h00
`define DASC_CTLB_RST      8'h00

// shortest frame: start + 7 data + 1 stop; width, stop and extra bit each add one
`define DASC_FRAME_BASE    4'h9

// default bit time in system clocks
`define DASC_BIT_CLKS      16'd0434

`endif

//--- dasc_top.v
`include "dasc_defs.vh"

// What this block does
// - shifter reloads from holding register automatically when a character ends
// - transmit line idles high when nothing to send
// - holding registers at 06H/07H, receive heads at 08H/09H
// - holding byte moves to shifter once shifter empties
// - holding register writable while shifter still sends
// - holding register reads back without disturbing transmission
// - assembled character moves automatically into four-character receive fifo
// - receive head is read-only and returns the oldest character
// - receiver keeps shifting while fifo is full
// - overrun flagged when character completes with shifter still occupied
// - four-entry status fifo holds parity, framing, overrun, break per character
// - status shows errors of oldest fifo character
// - wake-up enable ignored unless multidrop format selected
// - wake-up on: only flag-bit-one characters touch data and error flags
// - wake-up off: every character updates flags
// - reset clears wake-up enable
// - control A bit 6 enables the receiver
// - control A bit 5 enables the transmitter
// - clearing transmitter enable aborts current character
// - disabling transmitter keeps the holding-empty flag
// - transmitter enable forced low by reset and peripheral halt
// - data-available set when character enters empty fifo
// - overrun first shows when last good character is oldest, then sticks until error reset
// - three bits select 7/8 data, parity, 1/2 stops
// - multidrop frame: start, data, flag bit, stops, no parity
module dasc_top #(
  parameter BIT_CLKS = 434
) (
  // clock and reset
  input  wire       clock_in,
  input  wire       rst_in,
  input  wire       peripheral_halt_in,
  // i/o space access
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // serial pins
  input  wire       serial_in_pin0_in,
  input  wire       serial_in_pin1_in,
  output wire       serial_out_pin0_out,
  output wire       serial_out_pin1_out
);

  reg  [7:0] ctla_q [0:1];
  reg  [7:0] ctlb_q [0:1];
  wire [7:0] txh0;
  wire [7:0] txh1;
  wire [7:0] rxh0;
  wire [7:0] rxh1;
  wire [7:0] st0;
  wire [7:0] st1;
  wire       mpb0;
  wire       mpb1;
  wire [1:0] ctla_wr;
  wire [1:0] efr_clr;

  assign ctla_wr[0] = wr_in && addr_in == `DASC_ADDR_CTLA0;
  assign ctla_wr[1] = wr_in && addr_in == `DASC_ADDR_CTLA1;
  // writing a one to the error-reset bit clears the sticky error flags
  assign efr_clr[0] = ctla_wr[0] & wdata_in[`DASC_CA_EFR];
  assign efr_clr[1] = ctla_wr[1] & wdata_in[`DASC_CA_EFR];

  // control registers; halt forces the transmitter enable low
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctla_q[0] <= `DASC_CTLA_RST;
      ctla_q[1] <= `DASC_CTLA_RST;
      ctlb_q[0] <= `DASC_CTLB_RST;
      ctlb_q[1] <= `DASC_CTLB_RST;
    end else begin
      if (ctla_wr[0]) begin
        ctla_q[0] <= wdata_in;
      end
      if (ctla_wr[1]) begin
        ctla_q[1] <= wdata_in;
      end
      if (wr_in && addr_in == `DASC_ADDR_CTLB0) begin
        ctlb_q[0] <= wdata_in;
      end
      if (wr_in && addr_in == `DASC_ADDR_CTLB1) begin
        ctlb_q[1] <= wdata_in;
      end
      if (peripheral_halt_in) begin
        ctla_q[0][`DASC_CA_TXON] <= 1'b0;
        ctla_q[1][`DASC_CA_TXON] <= 1'b0;
      end
    end
  end

  // channel 0
  dasc_channel #(.BIT_CLKS(BIT_CLKS), .FIFO_AW(2)) u_ch0 (
    .clock_in           (clock_in),
    .rst_in             (rst_in),
    .halt_in            (peripheral_halt_in),
    .ctla_in            (ctla_q[0]),
    .ctlb_in            (ctlb_q[0]),
    .txh_wr_in          (wr_in && addr_in == `DASC_ADDR_TXH0),
    .wdata_in           (wdata_in),
    .rx_pop_in          (rd_in && addr_in == `DASC_ADDR_RXH0),
    .err_clr_in         (efr_clr[0]),
    .txh_out            (txh0),
    .rxh_out            (rxh0),
    .stat_out           (st0),
    .mpb_out            (mpb0),
    .serial_in_pin_in   (serial_in_pin0_in),
    .serial_out_pin_out (serial_out_pin0_out)
  );

  // channel 1
  dasc_channel #(.BIT_CLKS(BIT_CLKS), .FIFO_AW(2)) u_ch1 (
    .clock_in           (clock_in),
    .rst_in             (rst_in),
    .halt_in            (peripheral_halt_in),
    .ctla_in            (ctla_q[1]),
    .ctlb_in            (ctlb_q[1]),
    .txh_wr_in          (wr_in && addr_in == `DASC_ADDR_TXH1),
    .wdata_in           (wdata_in),
    .rx_pop_in          (rd_in && addr_in == `DASC_ADDR_RXH1),
    .err_clr_in         (efr_clr[1]),
    .txh_out            (txh1),
    .rxh_out            (rxh1),
    .stat_out           (st1),
    .mpb_out            (mpb1),
    .serial_in_pin_in   (serial_in_pin1_in),
    .serial_out_pin_out (serial_out_pin1_out)
  );

  // read mux; bit 3 of control A reads the last received flag bit
  always @* begin
    case (addr_in)
      `DASC_ADDR_CTLA0: rdata_out = {ctla_q[0][7:4], mpb0, ctla_q[0][2:0]};
      `DASC_ADDR_CTLA1: rdata_out = {ctla_q[1][7:4], mpb1, ctla_q[1][2:0]};
      `DASC_ADDR_CTLB0: rdata_out = ctlb_q[0];
      `DASC_ADDR_CTLB1: rdata_out = ctlb_q[1];
      `DASC_ADDR_STAT0: rdata_out = st0;
      `DASC_ADDR_STAT1: rdata_out = st1;
      `DASC_ADDR_TXH0:  rdata_out = txh0;
      `DASC_ADDR_TXH1:  rdata_out = txh1;
      `DASC_ADDR_RXH0:  rdata_out = rxh0;
      `DASC_ADDR_RXH1:  rdata_out = rxh1;
      default:          rdata_out = 8'h00;
    endcase
  end

endmodule

//--- dasc_assertions.sv
module dasc_assertions #(
  parameter BIT_CLKS = 434
) (
  // clock and reset
  input wire       clock_in,
  input wire       rst_in,
  input wire       peripheral_halt_in,
  // i/o space access
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  // serial pins
  input wire       serial_in_pin0_in,
  input wire       serial_in_pin1_in,
  input wire       serial_out_pin0_out,
  input wire       serial_out_pin1_out
);
  timeunit 1ns;
  timeprecision 1ns;
  reg        txon0_q;
  reg        wake_wr_q;
  reg [15:0] quiet_q;
  reg [15:0] low_q;
  wire       ca_wr;
  assign ca_wr = wr_in && addr_in == 8'h00;
  // shadow of channel 0 transmitter enable; quiet counts idle-high cycles with the transmitter on
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      txon0_q   <= 1'b0;
      wake_wr_q <= 1'b0;
      quiet_q   <= 16'h0000;
      low_q     <= 16'h0000;
    end else begin
      if (peripheral_halt_in)
        txon0_q <= 1'b0;
      else if (ca_wr)
        txon0_q <= wdata_in[5];
      if (ca_wr)
        wake_wr_q <= 1'b1;
      if (!txon0_q || !serial_out_pin0_out)
        quiet_q <= 16'h0000;
      else if (quiet_q != 16'hFFFF)
        quiet_q <= quiet_q + 16'h0001;
      low_q <= serial_out_pin0_out ? 16'h0000 : low_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_txh_wr; wr_in && addr_in == 8'h06; endsequence
  sequence s_txh_rd; rd_in && addr_in == 8'h06; endsequence
  // long idle means the holding register was empty, so a write must start a frame
  sequence s_quiet_wr; s_txh_wr ##0 (txon0_q && quiet_q >= 13 * BIT_CLKS); endsequence
  reset_idle_a: assert property ($fell(rst_in) |-> serial_out_pin0_out && serial_out_pin1_out)
    else $error("serial line not idle after reset");
  halt_idle_a: assert property (peripheral_halt_in [*3] |-> serial_out_pin0_out && serial_out_pin1_out)
    else $error("serial line not idle during halt");
  unmapped_zero_a: assert property (rd_in && addr_in > 8'h09 |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  txh_readback_a: assert property (s_txh_wr ##2 s_txh_rd |-> rdata_out == $past(wdata_in, 2))
    else $error("holding register readback wrong");
  start_latency_a: assert property (s_quiet_wr |-> ##[1:4] !serial_out_pin0_out)
    else $error("start bit did not follow write");
  bit_time_a: assert property ($rose(serial_out_pin0_out) |-> low_q % BIT_CLKS == 0)
    else $error("low run not whole bit times");
  wake_reset_a: assert property (rd_in && addr_in == 8'h00 && !wake_wr_q |-> !rdata_out[7])
    else $error("wake-up enable set after reset");
  txon_read_a: assert property (rd_in && addr_in == 8'h00 && !peripheral_halt_in |-> rdata_out[5] == txon0_q)
    else $error("transmitter enable readback wrong");
endmodule

bind dasc_top dasc_assertions #(.BIT_CLKS(BIT_CLKS)) i_chk (
  .clock_in(clock_in), .rst_in(rst_in), .peripheral_halt_in(peripheral_halt_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .serial_in_pin0_in(serial_in_pin0_in), .serial_in_pin1_in(serial_in_pin1_in),
  .serial_out_pin0_out(serial_out_pin0_out), .serial_out_pin1_out(serial_out_pin1_out)
);

//--- dasc_far_station.sv
module dasc_far_station #(
  parameter BIT_CLKS = 8
) (
  // clock
  input  wire clock_in,
  // serial lines
  input  wire line_in,
  output reg  line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [8:0] rx_bits;
  reg [7:0] rx_count;
  integer   b;
  integer   r;
  // line rests high between frames, like a pulled-up idle line
  initial begin
    line_out = 1'b1;
    rx_count = 8'h00;
  end
  // low start, data lsb first, optional flag bit, high stop; flag frames carry no parity
  task send(input [7:0] d, input flag_en, input flag_v);
    reg [10:0] f;
    begin
      f = {1'b1, flag_en ? flag_v : 1'b1, d, 1'b0};
      for (b = 0; b < 11; b++) begin
        @(negedge clock_in);
        line_out = f[b];
        repeat (BIT_CLKS - 1) @(negedge clock_in);
      end
    end
  endtask
  // mid-bit sampling of eight data bits and the first stop bit
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clock_in);
    for (r = 0; r < 9; r++) begin
      repeat (BIT_CLKS) @(posedge clock_in);
      rx_bits = {line_in, rx_bits[8:1]};
    end
    rx_count = rx_count + 8'h01;
  end
endmodule

//--- dasc_tb_top.sv
module dasc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 8;
  reg        clock_in;
  reg        rst_in;
  reg        peripheral_halt_in;
  reg  [7:0] addr_in;
  reg  [7:0] wdata_in;
  reg        wr_in;
  reg        rd_in;
  wire [7:0] rdata_out;
  wire       rx_line0;
  wire       tx_line0;
  wire       tx_line1;
  integer    n_fail;
  integer    cmp_count;
  integer    cyc;
  integer    k;
  reg  [7:0] q;
  dasc_top #(.BIT_CLKS(BC)) i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .peripheral_halt_in(peripheral_halt_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .serial_in_pin0_in(rx_line0), .serial_in_pin1_in(1'b1),
    .serial_out_pin0_out(tx_line0), .serial_out_pin1_out(tx_line1)
  );
  dasc_far_station #(.BIT_CLKS(BC)) i_far (
    .clock_in(clock_in), .line_in(tx_line0), .line_out(rx_line0)
  );
  always #10 clock_in = ~clock_in;
  // hang guard: the whole run needs under two thousand cycles
  always @(posedge clock_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one-cycle strobes, launched and dropped on falling edges
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clock_in);
      addr_in = a;
      wdata_in = d;
      wr_in = 1'b1;
      @(negedge clock_in);
      wr_in = 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(negedge clock_in);
      addr_in = a;
      rd_in = 1'b1;
      @(posedge clock_in);
      v = rdata_out;
      @(negedge clock_in);
      rd_in = 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      rd(a, q);
      chk(q & m, e);
    end
  endtask
  task wait_rx(input [7:0] n);
    begin
      k = 0;
      while (i_far.rx_count !== n && k < 3000) begin
        @(negedge clock_in);
        k = k + 1;
      end
      chk(i_far.rx_count, n);
    end
  endtask
  task t_regs;
    begin
      rdc(8'h00, 8'hFF, 8'h00);
      rdc(8'h0A, 8'hFF, 8'h00);
      rdc(8'h04, 8'h80, 8'h00);
    end
  endtask
  task t_tx;
    begin
      wr(8'h00, 8'h24);
      repeat (13 * BC + 4) @(negedge clock_in);
      wr(8'h06, 8'hA5);
      repeat (3) @(negedge clock_in);
      wr(8'h06, 8'h3C);
      rdc(8'h06, 8'hFF, 8'h3C);
      wait_rx(8'd1);
      chk(i_far.rx_bits[7:0], 8'hA5);
      chk({7'h00, i_far.rx_bits[8]}, 8'h01);
      wait_rx(8'd2);
      chk(i_far.rx_bits[7:0], 8'h3C);
    end
  endtask
  // six characters: four fill the fifo, the fifth waits in the shifter, the sixth overruns
  task t_rx;
    begin
      wr(8'h00, 8'h64);
      for (k = 1; k <= 6; k++)
        i_far.send(8'(8'h11 * k), 1'b0, 1'b0);
      rdc(8'h04, 8'h80, 8'h80);
      for (k = 1; k <= 5; k++) begin
        rdc(8'h04, 8'h78, (k >= 4) ? 8'h40 : 8'h00);
        rdc(8'h08, 8'hFF, 8'(8'h11 * k));
      end
      wr(8'h00, 8'h6C);
      rdc(8'h04, 8'hF8, 8'h00);
    end
  endtask
  task t_wake;
    begin
      wr(8'h02, 8'h40);
      wr(8'h00, 8'hE4);
      i_far.send(8'h12, 1'b1, 1'b0);
      rdc(8'h04, 8'h80, 8'h00);
      i_far.send(8'h34, 1'b1, 1'b1);
      rdc(8'h08, 8'hFF, 8'h34);
      rdc(8'h00, 8'h08, 8'h08);
      wr(8'h00, 8'h64);
      i_far.send(8'h56, 1'b1, 1'b0);
      rdc(8'h08, 8'hFF, 8'h56);
      wr(8'h02, 8'h00);
      wr(8'h00, 8'hE4);
      i_far.send(8'h78, 1'b0, 1'b0);
      rdc(8'h08, 8'hFF, 8'h78);
    end
  endtask
  // 7 data bits with even parity, both directions; the received byte carries a bad parity bit
  task t_par;
    begin
      wr(8'h00, 8'h62);
      wr(8'h06, 8'h07);
      wait_rx(8'd3);
      chk(i_far.rx_bits[7:0], 8'h87);
      i_far.send(8'h07, 1'b0, 1'b0);
      rdc(8'h04, 8'h78, 8'h20);
      rdc(8'h08, 8'hFF, 8'h07);
      wr(8'h00, 8'h6A);
      rdc(8'h04, 8'hF8, 8'h00);
    end
  endtask
  // all-zero byte so the abort lands on a low data bit
  task t_abort;
    begin
      wr(8'h01, 8'h24);
      wr(8'h07, 8'h00);
      repeat (3 * BC) @(negedge clock_in);
      chk({7'h00, tx_line1}, 8'h00);
      wr(8'h07, 8'hFF);
      rdc(8'h05, 8'h02, 8'h00);
      wr(8'h01, 8'h04);
      repeat (4) @(negedge clock_in);
      q = 8'h00;
      repeat (12 * BC) begin
        @(negedge clock_in);
        q = q | {7'h00, ~tx_line1};
      end
      chk(q, 8'h00);
      rdc(8'h05, 8'h02, 8'h00);
    end
  endtask
  task t_halt;
    begin
      peripheral_halt_in = 1'b1;
      repeat (4) @(negedge clock_in);
      peripheral_halt_in = 1'b0;
      rdc(8'h00, 8'h20, 8'h00);
    end
  endtask
  task conclude;
    begin
      $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    peripheral_halt_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (10) @(negedge clock_in);
    rst_in = 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_wake;
    t_par;
    t_abort;
    t_halt;
    conclude;
  end
endmodule
